// *** hw/ctp_consts.vh ***
// Constants for the cascaded 16-bit PWM / pulse generator / warm-up timer.
// Included by every design file of the timer; definitions only.
`ifndef CTP_CONSTS_VH
`define CTP_CONSTS_VH

// APB register byte offsets
`define CTP_OFF_CTRL 12'h000
`define CTP_OFF_DUTY 12'h004
`define CTP_OFF_PERIOD 12'h008
`define CTP_OFF_STATUS 12'h00C

// Control register fields
`define CTP_CTRL_MODE_LSB 0
`define CTP_CTRL_MODE_MSB 1
`define CTP_CTRL_RUN_BIT 2
`define CTP_CTRL_INIT_BIT 3
`define CTP_CTRL_SEL_LSB 4
`define CTP_CTRL_SEL_MSB 6
`define CTP_CTRL_TAP_BIT 7
`define CTP_CTRL_SLOW_BIT 8
`define CTP_CTRL_WIDTH 9
`define CTP_CTRL_RESET 9'h000

// Status register fields
`define CTP_STAT_FLOP_BIT 16
`define CTP_STAT_RUN_BIT 17

// Operating modes
`define CTP_MODE_PWM 2'h0
`define CTP_MODE_PPG 2'h1
`define CTP_MODE_WARM 2'h2

// Count clock source selects
`define CTP_SEL_DIV11 3'h0
`define CTP_SEL_DIV7 3'h1
`define CTP_SEL_DIV5 3'h2
`define CTP_SEL_DIV3 3'h3
`define CTP_SEL_LOWF 3'h4
`define CTP_SEL_DIV1 3'h5
`define CTP_SEL_FULL 3'h6
`define CTP_SEL_EXT 3'h7

// Divider widths
`define CTP_HF_DIV_BITS 11
`define CTP_LF_DIV_BITS 3

// Register reset values and count limit
`define CTP_DUTY_RESET 16'h0000
`define CTP_PERIOD_RESET 16'hFFFF
`define CTP_COUNT_MAX 16'hFFFF

`endif

// *** hw/ctp_prescaler.v ***
// Count clock prescaler of the cascaded timer: one tick per count step.
// Assumes pclk is the high-frequency clock; the low-frequency clock and the
// external count input are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
`include "ctp_consts.vh"

module ctp_prescaler (
    input wire pclk,
    input wire presetn,
    input wire [2:0] clk_sel,
    input wire divider_tap_select,
    input wire slow_mode,
    input wire low_freq_clock,
    input wire ext_count_input,
    output reg count_tick
);

    reg [`CTP_HF_DIV_BITS-1:0] hf_div_reg;
    reg [`CTP_LF_DIV_BITS-1:0] lf_div_reg;
    reg [2:0] lf_sync_reg;
    reg [2:0] ext_sync_reg;
    reg tick_next;
    wire lf_edge;
    wire ext_edge;
    wire lf_div8;

    // All ones in the lowest n bits of the divider marks a tap rollover
    function hf_tap;
        input [`CTP_HF_DIV_BITS-1:0] div;
        input integer n;
        integer i;
        begin
            hf_tap = 1'b1;
            for (i = 0; i < `CTP_HF_DIV_BITS; i = i + 1) begin
                if (i < n && !div[i]) begin
                    hf_tap = 1'b0;
                end
            end
        end
    endfunction

    assign lf_edge = lf_sync_reg[1] & ~lf_sync_reg[2];
    assign ext_edge = ext_sync_reg[1] & ~ext_sync_reg[2];
    assign lf_div8 = lf_edge & (&lf_div_reg);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hf_div_reg <= {`CTP_HF_DIV_BITS{1'b0}};
            lf_div_reg <= {`CTP_LF_DIV_BITS{1'b0}};
            lf_sync_reg <= 3'h0;
            ext_sync_reg <= 3'h0;
            count_tick <= 1'b0;
        end else begin
            hf_div_reg <= hf_div_reg + 11'h001;
            lf_sync_reg <= {lf_sync_reg[1:0], low_freq_clock};
            ext_sync_reg <= {ext_sync_reg[1:0], ext_count_input};
            if (lf_edge) begin
                lf_div_reg <= lf_div_reg + 3'h1;
            end
            count_tick <= tick_next;
        end
    end

    // Source choice; in slow operation only the low-frequency, external and DIV11 (low-frequency clock divided by 8) selects tick
    always @* begin
        tick_next = 1'b0;
        case (clk_sel)
            `CTP_SEL_DIV11: tick_next = (divider_tap_select | slow_mode) ? lf_div8 :
                hf_tap(hf_div_reg, 11);
            `CTP_SEL_DIV7: tick_next = ~slow_mode & hf_tap(hf_div_reg, 7);
            `CTP_SEL_DIV5: tick_next = ~slow_mode & hf_tap(hf_div_reg, 5);
            `CTP_SEL_DIV3: tick_next = ~slow_mode & hf_tap(hf_div_reg, 3);
            `CTP_SEL_LOWF: tick_next = lf_edge;
            `CTP_SEL_DIV1: tick_next = ~slow_mode & hf_tap(hf_div_reg, 1);
            `CTP_SEL_FULL: tick_next = ~slow_mode;
            `CTP_SEL_EXT: tick_next = ext_edge;
            default: tick_next = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// *** hw/ctp_timer.v ***
// Cascaded 16-bit timer with PWM, pulse generator and warm-up modes, APB slave.
// Assumes a single APB4 master on pclk; output pins drive external circuitry.
`timescale 1ns/1ps
`default_nettype none
`include "ctp_consts.vh"

module ctp_timer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire low_freq_clock,
    input wire ext_count_input,
    output reg pwm_out_n,
    output reg pulse_gen_out_n,
    output reg cascade_match_irq
);

    // Counter sequencer states
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [`CTP_CTRL_WIDTH-1:0] ctrl_reg;
    reg [`CTP_CTRL_WIDTH-1:0] ctrl_next;
    reg [15:0] duty_buf_reg;
    reg [15:0] duty_buf_next;
    reg [15:0] duty_shift_reg;
    reg [15:0] duty_shift_next;
    reg [15:0] period_reg;
    reg [15:0] period_next;
    reg [7:0] lo_count_reg;
    reg [7:0] lo_count_next;
    reg [7:0] hi_count_reg;
    reg [7:0] hi_count_next;
    reg output_toggle_flop_reg;
    reg output_toggle_flop_next;
    reg irq_next;
    reg [31:0] rdata_next;
    reg slverr_next;

    wire count_tick;
    wire access;
    wire wr_en;
    wire wr_ctrl;
    wire wr_duty;
    wire wr_period;
    wire [1:0] mode;
    wire running;
    wire [15:0] count;
    wire [15:0] duty_active;
    wire lo_carry;
    wire duty_hit;
    wire end_hit;
    wire toggling_mode;

    // Register offset decode
    function addr_is;
        input [11:0] addr;
        input [11:0] offset;
        begin
            addr_is = (addr[11:2] == offset[11:2]);
        end
    endfunction

    // Byte lane merge into a 16-bit register, low lane first
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
            merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    ctp_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .clk_sel(ctrl_reg[`CTP_CTRL_SEL_MSB:`CTP_CTRL_SEL_LSB]),
        .divider_tap_select(ctrl_reg[`CTP_CTRL_TAP_BIT]),
        .slow_mode(ctrl_reg[`CTP_CTRL_SLOW_BIT]),
        .low_freq_clock(low_freq_clock),
        .ext_count_input(ext_count_input),
        .count_tick(count_tick)
    );

    assign access = psel & penable;
    assign wr_en = access & pwrite & pready;
    assign wr_ctrl = wr_en & addr_is(paddr, `CTP_OFF_CTRL);
    assign wr_duty = wr_en & addr_is(paddr, `CTP_OFF_DUTY);
    assign wr_period = wr_en & addr_is(paddr, `CTP_OFF_PERIOD);

    assign mode = ctrl_reg[`CTP_CTRL_MODE_MSB:`CTP_CTRL_MODE_LSB];
    assign running = (state_reg == ST_RUN);
    assign toggling_mode = (mode == `CTP_MODE_PWM) | (mode == `CTP_MODE_PPG);
    assign count = {hi_count_reg, lo_count_reg};
    assign lo_carry = (lo_count_reg == 8'hFF);
    assign duty_active = (mode == `CTP_MODE_PWM) ? duty_shift_reg : duty_buf_reg;
    assign duty_hit = toggling_mode & (count == duty_active);

    // Cycle end: overflow, full period match, or upper-byte period match
    assign end_hit = ((mode == `CTP_MODE_PWM) & (count == `CTP_COUNT_MAX)) |
        ((mode == `CTP_MODE_PPG) & (count == period_reg)) |
        ((mode == `CTP_MODE_WARM) & (hi_count_reg == period_reg[15:8]));

    // APB slave: one wait state, read data and error registered
    always @* begin
        rdata_next = 32'h00000000;
        slverr_next = 1'b0;
        if (addr_is(paddr, `CTP_OFF_CTRL)) begin
            rdata_next[`CTP_CTRL_WIDTH-1:0] = ctrl_reg;
        end else if (addr_is(paddr, `CTP_OFF_DUTY)) begin
            rdata_next[15:0] = duty_active;
        end else if (addr_is(paddr, `CTP_OFF_PERIOD)) begin
            rdata_next[15:0] = period_reg;
        end else if (addr_is(paddr, `CTP_OFF_STATUS)) begin
            rdata_next[15:0] = count;
            rdata_next[`CTP_STAT_FLOP_BIT] = output_toggle_flop_reg;
            rdata_next[`CTP_STAT_RUN_BIT] = running;
        end else begin
            slverr_next = 1'b1;
        end
    end

    // Register writes and the counter sequencer
    always @* begin
        ctrl_next = ctrl_reg;
        duty_buf_next = duty_buf_reg;
        duty_shift_next = duty_shift_reg;
        period_next = period_reg;
        state_next = state_reg;
        lo_count_next = lo_count_reg;
        hi_count_next = hi_count_reg;
        output_toggle_flop_next = output_toggle_flop_reg;
        irq_next = 1'b0;

        if (wr_ctrl) begin
            ctrl_next = pwdata[`CTP_CTRL_WIDTH-1:0];
        end
        if (wr_duty) begin
            duty_buf_next = merge16(duty_buf_reg, pwdata, pstrb);
            if (!running) begin
                duty_shift_next = duty_buf_next;
            end
        end
        if (wr_period) begin
            period_next = merge16(period_reg, pwdata, pstrb);
        end

        case (state_reg)
            ST_IDLE: begin
                if (wr_ctrl) begin
                    // Flop follows the initial level only while stopped
                    output_toggle_flop_next = pwdata[`CTP_CTRL_INIT_BIT];
                    if (pwdata[`CTP_CTRL_RUN_BIT]) begin
                        state_next = ST_RUN;
                        lo_count_next = 8'h00;
                        hi_count_next = 8'h00;
                    end
                end
            end
            ST_RUN: begin
                if (wr_ctrl && !pwdata[`CTP_CTRL_RUN_BIT]) begin
                    state_next = ST_IDLE;
                end else if (count_tick) begin
                    if (end_hit) begin
                        lo_count_next = 8'h00;
                        hi_count_next = 8'h00;
                        irq_next = 1'b1;
                        if (mode == `CTP_MODE_PWM) begin
                            duty_shift_next = duty_buf_next;
                        end
                    end else begin
                        lo_count_next = lo_count_reg + 8'h01;
                        hi_count_next = hi_count_reg + {7'h00, lo_carry};
                    end
                    output_toggle_flop_next = output_toggle_flop_reg ^ duty_hit ^
                        (end_hit & toggling_mode);
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            ctrl_reg <= `CTP_CTRL_RESET;
            duty_buf_reg <= `CTP_DUTY_RESET;
            duty_shift_reg <= `CTP_DUTY_RESET;
            period_reg <= `CTP_PERIOD_RESET;
            lo_count_reg <= 8'h00;
            hi_count_reg <= 8'h00;
            output_toggle_flop_reg <= 1'b0;
            cascade_match_irq <= 1'b0;
            pwm_out_n <= 1'b1;
            pulse_gen_out_n <= 1'b1;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            duty_buf_reg <= duty_buf_next;
            duty_shift_reg <= duty_shift_next;
            period_reg <= period_next;
            lo_count_reg <= lo_count_next;
            hi_count_reg <= hi_count_next;
            output_toggle_flop_reg <= output_toggle_flop_next;
            cascade_match_irq <= irq_next;
            pwm_out_n <= ~output_toggle_flop_next;
            pulse_gen_out_n <= ~output_toggle_flop_next;
            pready <= access & ~pready;
            if (access && !pready) begin
                prdata <= pwrite ? 32'h00000000 : rdata_next;
                pslverr <= slverr_next;
            end else begin
                prdata <= 32'h00000000;
                pslverr <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// *** testbench/ctp_load.sv ***
// Load on the PWM output pin, plus slow clock and external count sources.
// Assumes pclk stands for the high-frequency clock.
`timescale 1ns/1ps
`default_nettype none
module ctp_load (
    input wire logic pclk,
    input wire logic pwm_out_n,
    output var logic low_freq_clock,
    output var logic ext_count_input,
    output var int n_pulse
);
    int div_reg = 0;
    initial begin
        low_freq_clock = 1'b0;
        ext_count_input = 1'b0;
        n_pulse = 0;
    end
    always @(posedge pclk) begin
        div_reg <= div_reg + 1;
        if (div_reg % 8 == 7) ext_count_input <= !ext_count_input;
        if (div_reg % 16 == 15) low_freq_clock <= !low_freq_clock;
    end
    // Port latch is high, so the load sees the pin itself
    always @(negedge pwm_out_n) n_pulse <= n_pulse + 1;
endmodule
`default_nettype wire

// *** testbench/ctp_timer_assertions.sv ***
// Port checker for the cascaded timer.
// Sees only ctp_timer ports; bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module ctp_timer_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pwm_out_n,
    input wire logic pulse_gen_out_n,
    input wire logic cascade_match_irq
);
    logic [1:0] mode_reg;
    logic run_reg;
    wire ctrl_wr = psel && penable && pready && pwrite && paddr[11:2] == 10'h000;
    wire stop_wr = ctrl_wr && run_reg && !pwdata[2];
    // Mirror of mode and run from completed control writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= 2'h0;
            run_reg <= 1'b0;
        end else if (ctrl_wr) begin
            mode_reg <= pwdata[1:0];
            run_reg <= pwdata[2];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    a_ready_wait: assert property (s_access |-> !pready ##1 pready)
        else $error("ready timing wrong");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    a_err_decode: assert property (pready |-> pslverr == (paddr[11:4] != 8'h00))
        else $error("slave error wrong");
    a_idle_bus: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("bus not idle");
    a_pins_equal: assert property (pwm_out_n == pulse_gen_out_n)
        else $error("pins differ");
    a_reset_pin: assert property ($rose(presetn) |-> pwm_out_n && !cascade_match_irq)
        else $error("pin after reset");
    a_stop_hold: assert property (stop_wr |=> $stable(pwm_out_n)[*3])
        else $error("pin moved on stop");
    a_irq_run: assert property (cascade_match_irq |-> run_reg || $past(run_reg))
        else $error("irq while stopped");
    a_irq_toggle: assert property (cascade_match_irq && mode_reg != 2'h2
        |-> pwm_out_n != $past(pwm_out_n)) else $error("no toggle at end");
endmodule
`default_nettype wire

// *** testbench/ctp_timer_bench.sv ***
// Self-checking bench for the cascaded timer.
// Assumes ctp_timer, ctp_load and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ctp_consts.vh"
`define CHK(nm, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("unexpected %s: exp %0h got %0h", nm, e, g); \
    end \
end
module ctp_timer_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    wire [31:0] prdata;
    wire pready, pslverr, pwm_out_n, pulse_gen_out_n, cascade_match_irq, lfc, ext;
    int n_mismatch = 0;
    int compares = 0;
    int n_pulse;
    logic [31:0] q_dat[$];
    logic q_err[$];
    logic [31:0] e_dat;
    logic e_err;
    always #2 pclk = ~pclk;
    ctp_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .low_freq_clock(lfc), .ext_count_input(ext),
        .pwm_out_n(pwm_out_n), .pulse_gen_out_n(pulse_gen_out_n),
        .cascade_match_irq(cascade_match_irq));
    ctp_load u_load (.pclk(pclk), .pwm_out_n(pwm_out_n), .low_freq_clock(lfc),
        .ext_count_input(ext), .n_pulse(n_pulse));
    // Monitor: oldest note against each completed transfer
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            e_err = q_err.pop_front();
            e_dat = q_dat.pop_front();
            `CHK("pslverr", e_err, pslverr)
            if (!pwrite) `CHK("prdata", e_dat, prdata)
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s, input logic [31:0] e);
        q_err.push_back(a[11:4] != 8'h00);
        q_dat.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic r, input logic i,
            input logic [2:0] s);
        ctl = {24'h0, 1'b1, s, i, r, m};
    endfunction
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (cascade_match_irq !== 1'b1 && n < 70000);
        `CHK("irq seen", 1'b1, cascade_match_irq)
        `CHK("pin at end", 1'b1, pwm_out_n)
    endtask
    task automatic measure(input int e);
        int n;
        wait_irq(n);
        wait_irq(n);
        `CHK("interval", e, n)
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(4 * 95000);
        n_mismatch++;
        close_out;
    end
    initial begin
        int i;
        int n;
        int divs[8] = '{256, 128, 32, 8, 32, 2, 1, 16};
        logic [31:0] r;
        void'($urandom(89609));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("pin reset", 1'b1, pwm_out_n)
        apb(0, `CTP_OFF_CTRL, 0, 4'hF, 0);
        apb(0, `CTP_OFF_PERIOD, 0, 4'hF, 32'hFFFF);
        apb(0, `CTP_OFF_STATUS, 0, 4'hF, 0);
        apb(0, 12'h010, 0, 4'hF, 0);
        apb(1, 12'h020, 32'hFFFF, 4'hF, 0);
        for (i = 0; i < 3; i++) begin
            r = $urandom;
            apb(1, `CTP_OFF_DUTY, r, 4'h1, 0);
            apb(1, `CTP_OFF_DUTY, r, 4'h2, 0);
            apb(0, `CTP_OFF_DUTY, 0, 4'hF, r & 32'hFFFF);
            apb(1, `CTP_OFF_PERIOD, r >> 16, 4'h3, 0);
            apb(0, `CTP_OFF_PERIOD, 0, 4'hF, r >> 16);
        end
        apb(1, `CTP_OFF_PERIOD, 9, 4'hF, 0);
        apb(1, `CTP_OFF_DUTY, 3, 4'hF, 0);
        for (i = 0; i < 8; i++) begin
            apb(1, `CTP_OFF_CTRL, ctl(`CTP_MODE_PPG, 1, 0, 3'(i)), 4'hF, 0);
            measure(10 * divs[i]);
            apb(1, `CTP_OFF_CTRL, ctl(`CTP_MODE_PPG, 0, 0, 3'(i)), 4'hF, 0);
        end
        // Slow operation blocks the full-rate source: the count must not move
        apb(1, `CTP_OFF_CTRL, ctl(`CTP_MODE_PPG, 0, 0, 6) | 32'h100, 4'hF, 0);
        apb(1, `CTP_OFF_CTRL, ctl(`CTP_MODE_PPG, 1, 0, 6) | 32'h100, 4'hF, 0);
        apb(0, `CTP_OFF_STATUS, 0, 4'hF, 32'h20000);
        apb(1, `CTP_OFF_CTRL, ctl(`CTP_MODE_PPG, 0, 0, 6), 4'hF, 0);
        apb(1, `CTP_OFF_CTRL, ctl(`CTP_MODE_PPG, 0, 1, 6), 4'hF, 0);
        repeat (2) @(posedge pclk);
        `CHK("pin init", 1'b0, pwm_out_n)
        apb(1, `CTP_OFF_CTRL, ctl(`CTP_MODE_PPG, 0, 0, 6), 4'hF, 0);
        r = $urandom;
        apb(1, `CTP_OFF_PERIOD, {16'h0, 8'h02, r[7:0]}, 4'hF, 0);
        apb(1, `CTP_OFF_CTRL, ctl(`CTP_MODE_WARM, 1, 0, 6), 4'hF, 0);
        measure(32'h201);
        apb(1, `CTP_OFF_CTRL, ctl(`CTP_MODE_WARM, 0, 0, 6), 4'hF, 0);
        apb(1, `CTP_OFF_DUTY, 32'h10, 4'hF, 0);
        apb(1, `CTP_OFF_CTRL, ctl(`CTP_MODE_PWM, 1, 0, 6), 4'hF, 0);
        apb(1, `CTP_OFF_DUTY, 32'h20, 4'hF, 0);
        apb(0, `CTP_OFF_DUTY, 0, 4'hF, 32'h10);
        wait_irq(n);
        apb(0, `CTP_OFF_DUTY, 0, 4'hF, 32'h20);
        `CHK("pulses", 1'b1, n_pulse > 0)
        close_out;
    end
endmodule
bind ctp_timer ctp_timer_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_out_n(pwm_out_n),
    .pulse_gen_out_n(pulse_gen_out_n), .cascade_match_irq(cascade_match_irq));
`default_nettype wire
